// ===== rtl/srp_core.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module srp_core #(
  parameter int unsigned CYCLE_CLKS = srp_pkg::CYCLE_CLKS,
  parameter int unsigned ERR_W      = 48
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire srp_pkg::srp_enc_s m_enc,
  input  wire srp_pkg::srp_enc_s s_enc,
  input  wire logic             trim_lead,
  input  wire logic             trim_lag,
  input  wire logic             idx_master,
  input  wire logic             idx_slave,
  output logic                  alarm,
  output logic                  index_ok,
  output logic      [31:0]      corr_out,
  output logic                  irq
);
  logic [1:0] rst_sync_q;
  logic       rst_ni;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_ni = rst_sync_q[1];

  function automatic logic [31:0] clampu(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Parameter store
  logic [31:0] fact_m_q, fact_s_q, trim_q, integ_t_q, imp_q;
  logic [31:0] alert_q, cdiv_q, iwin_q, imode_q, mode_q;
  logic signed [31:0] offs_q;
  logic [srp_pkg::N_EV-1:0] istat_q, ien_q, ev;

  logic wr_acc, rd_setup;
  assign wr_acc   = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  logic signed [31:0] offs_cl;
  assign offs_cl = ($signed(pwdata) > $signed(srp_pkg::IMP_MAX)) ? $signed(srp_pkg::IMP_MAX) :
                   ($signed(pwdata) < -$signed(srp_pkg::IMP_MAX)) ? -$signed(srp_pkg::IMP_MAX) :
                   $signed(pwdata);

  // Mode 4 factor stepping
  logic        fstep_up, fstep_dn;
  logic [31:0] fact_step;
  assign fact_step = fstep_up ? clampu(fact_m_q + 32'h1, srp_pkg::FACT_MIN, srp_pkg::FACT_MAX) :
                     fstep_dn ? clampu(fact_m_q - 32'h1, srp_pkg::FACT_MIN, srp_pkg::FACT_MAX) :
                     fact_m_q;

  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      fact_m_q  <= srp_pkg::FACT_RST;
      fact_s_q  <= srp_pkg::FACT_RST;
      trim_q    <= srp_pkg::TRIM_MIN;
      integ_t_q <= 32'h0;
      imp_q     <= srp_pkg::IMP_MIN;
      offs_q    <= 32'sh0;
      alert_q   <= srp_pkg::ALERT_RST;
      cdiv_q    <= 32'h0;
      iwin_q    <= srp_pkg::WIN_MIN;
      imode_q   <= 32'h0;
      mode_q    <= 32'h0;
    end else if (wr_acc) begin
      case (paddr)
        srp_pkg::A_FACT_M: fact_m_q  <= clampu(pwdata, srp_pkg::FACT_MIN, srp_pkg::FACT_MAX);
        srp_pkg::A_FACT_S: fact_s_q  <= clampu(pwdata, srp_pkg::FACT_MIN, srp_pkg::FACT_MAX);
        srp_pkg::A_TRIM:   trim_q    <= clampu(pwdata, srp_pkg::TRIM_MIN, srp_pkg::TRIM_MAX);
        srp_pkg::A_INTEG:  integ_t_q <= clampu(pwdata, 32'h0, srp_pkg::INTEG_MAX);
        srp_pkg::A_IMP:    imp_q     <= clampu(pwdata, srp_pkg::IMP_MIN, srp_pkg::IMP_MAX);
        srp_pkg::A_OFFS:   offs_q    <= offs_cl;
        srp_pkg::A_ALERT:  alert_q   <= clampu(pwdata, 32'h0, srp_pkg::WIN9999);
        srp_pkg::A_CDIV:   cdiv_q    <= clampu(pwdata, 32'h0, srp_pkg::SHIFT_MAX);
        srp_pkg::A_IWIN:   iwin_q    <= clampu(pwdata, srp_pkg::WIN_MIN, srp_pkg::WIN9999);
        srp_pkg::A_IMODE:  imode_q   <= clampu(pwdata, 32'h0, srp_pkg::IMODE_MAX);
        srp_pkg::A_MODE:   mode_q    <= clampu(pwdata, 32'h0, srp_pkg::MODE_MAX);
        default: ;
      endcase
    end else begin
      fact_m_q <= fact_step;
    end
  end

  // Mode decode
  logic [3:0] mode4;
  logic       unity, idx_en, step_mode, fact_mode;
  assign mode4     = mode_q[3:0];
  assign unity     = (mode4 == srp_pkg::MODE_U2) | (mode4 == srp_pkg::MODE_U6) |
                     (mode4 == srp_pkg::MODE_U8);
  assign idx_en    = (imode_q != 32'h0);
  assign step_mode = (mode4 == srp_pkg::MODE_STEP);
  assign fact_mode = (mode4 == srp_pkg::MODE_FACT);

  // Control cycle timebase
  logic [31:0] cyc_q;
  logic        tick;
  assign tick = (cyc_q == CYCLE_CLKS - 1);
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) cyc_q <= 32'h0;
    else cyc_q <= tick ? 32'h0 : cyc_q + 32'h1;
  end

  // Marker edge detection
  logic mi_q, si_q, mi_rise, si_rise;
  assign mi_rise = idx_master & ~mi_q;
  assign si_rise = idx_slave & ~si_q;
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      mi_q <= 1'b0;
      si_q <= 1'b0;
    end else begin
      mi_q <= idx_master;
      si_q <= idx_slave;
    end
  end

  // Encoder pulse counts within one control cycle
  logic signed [15:0] m_cnt_q, s_cnt_q, m_now, s_now;
  assign m_now = m_enc.inc ? (m_enc.dir ? -16'sh1 : 16'sh1) : 16'sh0;
  assign s_now = s_enc.inc ? (s_enc.dir ? -16'sh1 : 16'sh1) : 16'sh0;
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      m_cnt_q <= 16'sh0;
      s_cnt_q <= 16'sh0;
    end else begin
      m_cnt_q <= tick ? m_now : m_cnt_q + m_now;
      s_cnt_q <= tick ? s_now : s_cnt_q + s_now;
    end
  end

  // Trim rate divider
  logic        trim_act, trim_step;
  logic [31:0] trim_cnt_q;
  assign trim_act  = (trim_lead ^ trim_lag) | (fact_mode & (idx_master ^ idx_slave));
  assign trim_step = tick & trim_act & (trim_cnt_q >= trim_q - 32'h1);
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) trim_cnt_q <= 32'h0;
    else if (!trim_act || trim_step) trim_cnt_q <= 32'h0;
    else if (tick) trim_cnt_q <= trim_cnt_q + 32'h1;
  end
  assign fstep_up = trim_step & fact_mode & idx_master;
  assign fstep_dn = trim_step & fact_mode & idx_slave;

  // Slave pulses since master marker
  logic signed [31:0] since_q, diff;
  logic               idx_cap;
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) since_q <= 32'sh0;
    else if (mi_rise) since_q <= 32'sh0;
    else if (s_enc.inc && !s_enc.dir)
      since_q <= (since_q >= $signed(imp_q) - 32'sh1) ? 32'sh0 : since_q + 32'sh1;
    else if (s_enc.inc)
      since_q <= (since_q == 32'sh0) ? $signed(imp_q) - 32'sh1 : since_q - 32'sh1;
  end
  assign diff    = since_q - offs_q;
  assign idx_cap = idx_en & ~fact_mode & si_rise;

  logic [31:0] diff_abs;
  assign diff_abs = diff[31] ? 32'(-diff) : 32'(diff);
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) index_ok <= 1'b0;
    else if (!idx_en) index_ok <= 1'b0;
    else if (idx_cap) index_ok <= (diff_abs <= iwin_q);
  end

  // Pending increment adjustments, applied at the end of this cycle
  logic signed [31:0] adj_q, adj_now;
  assign adj_now = (trim_step & ~fact_mode ? (trim_lead ? 32'sh1 : -32'sh1) : 32'sh0) +
                   (idx_cap ? -diff : 32'sh0) +
                   (step_mode & mi_rise ? offs_q : 32'sh0);
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) adj_q <= 32'sh0;
    else adj_q <= tick ? 32'sh0 : adj_q + adj_now;
  end

  // Phase error in 1e-4 increment units
  logic signed [ERR_W-1:0] err_q, err_d, prod_m, prod_s, adj_sc;
  logic [31:0]             f_m, f_s;
  assign f_m    = unity ? srp_pkg::SCALE : fact_m_q;
  assign f_s    = unity ? srp_pkg::SCALE : fact_s_q;
  assign prod_m = ERR_W'(m_cnt_q * $signed({1'b0, f_m[30:0]}));
  assign prod_s = ERR_W'(s_cnt_q * $signed({1'b0, f_s[30:0]}));
  assign adj_sc = ERR_W'((adj_q + adj_now) * $signed(srp_pkg::SCALE));
  assign err_d  = err_q + prod_m - prod_s + adj_sc;
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) err_q <= '0;
    else if (tick) err_q <= err_d;
  end

  // Correction divider and alarm
  logic signed [ERR_W-1:0] err_inc, err_div;
  logic [ERR_W-1:0]        div_abs;
  logic                    alarm_d;
  assign err_inc = err_q / $signed({1'b0, srp_pkg::SCALE});
  assign err_div = err_inc >>> cdiv_q[3:0];
  assign div_abs = err_div[ERR_W-1] ? ERR_W'(-err_div) : ERR_W'(err_div);
  assign alarm_d = (div_abs > ERR_W'(alert_q));

  // Integrator; host is expected to zero its time in index modes
  logic [31:0]        int_cnt_q;
  logic signed [31:0] integ_q;
  logic               int_step;
  assign int_step = tick & (integ_t_q != 32'h0) & (int_cnt_q >= integ_t_q - 32'h1);
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      int_cnt_q <= 32'h0;
      integ_q   <= 32'sh0;
    end else if (integ_t_q == 32'h0) begin
      int_cnt_q <= 32'h0;
      integ_q   <= 32'sh0;
    end else if (int_step) begin
      int_cnt_q <= 32'h0;
      if (err_div != '0) integ_q <= integ_q + (err_div[ERR_W-1] ? -32'sh1 : 32'sh1);
    end else if (tick) begin
      int_cnt_q <= int_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      alarm    <= 1'b0;
      corr_out <= 32'h0;
    end else begin
      alarm    <= alarm_d;
      corr_out <= 32'(err_div) + integ_q;
    end
  end

  // Interrupt status: set wins over clear
  assign ev[srp_pkg::EV_ALARM] = alarm_d & ~alarm;
  assign ev[srp_pkg::EV_INDEX] = idx_cap;
  assign ev[srp_pkg::EV_TRIM]  = trim_step;
  logic [srp_pkg::N_EV-1:0] iclr;
  assign iclr = (wr_acc && paddr == srp_pkg::A_ICLR) ? pwdata[srp_pkg::N_EV-1:0] : '0;
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      istat_q <= '0;
      ien_q   <= '0;
      irq     <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~iclr) | ev;
      if (wr_acc && paddr == srp_pkg::A_IEN) ien_q <= pwdata[srp_pkg::N_EV-1:0];
      irq     <= |(((istat_q & ~iclr) | ev) & ien_q);
    end
  end

  // APB read mux
  logic [31:0] rd_mux;
  logic        mapped;
  assign mapped = (paddr <= srp_pkg::A_ICLR) && (paddr[1:0] == 2'h0) &&
                  (paddr != 8'h2C);
  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      srp_pkg::A_FACT_M: rd_mux = fact_m_q;
      srp_pkg::A_FACT_S: rd_mux = fact_s_q;
      srp_pkg::A_TRIM:   rd_mux = trim_q;
      srp_pkg::A_INTEG:  rd_mux = integ_t_q;
      srp_pkg::A_IMP:    rd_mux = imp_q;
      srp_pkg::A_OFFS:   rd_mux = offs_q;
      srp_pkg::A_ALERT:  rd_mux = alert_q;
      srp_pkg::A_CDIV:   rd_mux = cdiv_q;
      srp_pkg::A_IWIN:   rd_mux = iwin_q;
      srp_pkg::A_IMODE:  rd_mux = imode_q;
      srp_pkg::A_MODE:   rd_mux = mode_q;
      srp_pkg::A_ERR:    rd_mux = 32'(err_div);
      srp_pkg::A_STAT:   rd_mux = {30'h0, index_ok, alarm};
      srp_pkg::A_ISTAT:  rd_mux = {29'h0, istat_q};
      srp_pkg::A_IEN:    rd_mux = {29'h0, ien_q};
      default:           rd_mux = 32'h0;
    endcase
  end

  // One wait-free access phase after each setup
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & ~mapped;
      if (rd_setup) prdata <= (pwrite || !mapped) ? 32'h0 : rd_mux;
    end
  end
endmodule // srp_core

// ===== shared/srp_pkg.sv
// Functional notes
// - Parameter set is retained in storage; written only through the configuration port, except master factor stepping in mode 4.
// - Every loaded parameter is clamped into its permitted range.
// - Index-only parameters act only while an index mode is selected; the offset also sets the mode 3 step on the master marker rise without one.
// - Master increments are multiplied by master factor, 0.0001 to 9.9999.
// - Slave increments are multiplied by slave factor, same range.
// - Modes 2, 6 and 8 force unity scaling 1.0000.
// - Trim and mode 4 factor stepping advance once per trim-time control cycles.
// - Trim time 001 to 999 cycles per increment; 001 is fastest.
// - Integrator time 000 disables integration; N cycles per increment otherwise.
// - Index modes use N slave pulses between slave markers, 1 to 999999.
// - Offset is displacement from master marker rise to slave marker rise.
// - Alarm asserts while error lies outside tolerance window 0000 to 9999.
// - Alarm compares the error after the correction divider.
// - Lead trim advances slave position, lag trim retards it.
// - Marker inputs act on rising edges; mode 4 steps master factor instead.
package srp_pkg;
  localparam int unsigned CLK_NS       = 8;
  localparam int unsigned CTRL_CYC_US  = 100;
  localparam int unsigned CYCLE_CLKS   = CTRL_CYC_US * 1000 / CLK_NS;
  localparam logic [31:0] SCALE        = 32'h0000_2710;
  localparam logic [31:0] FACT_MIN     = 32'h0000_0001;
  localparam logic [31:0] FACT_MAX     = 32'h0001_869F;
  localparam logic [31:0] FACT_RST     = 32'h0000_2710;
  localparam logic [31:0] TRIM_MIN     = 32'h0000_0001;
  localparam logic [31:0] TRIM_MAX     = 32'h0000_03E7;
  localparam logic [31:0] INTEG_MAX    = 32'h0000_03E7;
  localparam logic [31:0] IMP_MIN      = 32'h0000_0001;
  localparam logic [31:0] IMP_MAX      = 32'h000F_423F;
  localparam logic [31:0] WIN9999      = 32'h0000_270F;
  localparam logic [31:0] WIN_MIN      = 32'h0000_0001;
  localparam logic [31:0] SHIFT_MAX    = 32'h0000_000F;
  localparam logic [31:0] IMODE_MAX    = 32'h0000_0003;
  localparam logic [31:0] MODE_MAX     = 32'h0000_0009;
  localparam logic [31:0] ALERT_RST    = 32'h0000_001E;
  localparam logic [3:0]  MODE_STEP    = 4'h3;
  localparam logic [3:0]  MODE_FACT    = 4'h4;
  localparam logic [3:0]  MODE_U2      = 4'h2;
  localparam logic [3:0]  MODE_U6      = 4'h6;
  localparam logic [3:0]  MODE_U8      = 4'h8;
  localparam logic [7:0]  A_FACT_M     = 8'h00;
  localparam logic [7:0]  A_FACT_S     = 8'h04;
  localparam logic [7:0]  A_TRIM       = 8'h08;
  localparam logic [7:0]  A_INTEG      = 8'h0C;
  localparam logic [7:0]  A_IMP        = 8'h10;
  localparam logic [7:0]  A_OFFS       = 8'h14;
  localparam logic [7:0]  A_ALERT      = 8'h18;
  localparam logic [7:0]  A_CDIV       = 8'h1C;
  localparam logic [7:0]  A_IWIN       = 8'h20;
  localparam logic [7:0]  A_IMODE      = 8'h24;
  localparam logic [7:0]  A_MODE       = 8'h28;
  localparam logic [7:0]  A_ERR        = 8'h30;
  localparam logic [7:0]  A_STAT       = 8'h34;
  localparam logic [7:0]  A_ISTAT      = 8'h38;
  localparam logic [7:0]  A_IEN        = 8'h3C;
  localparam logic [7:0]  A_ICLR       = 8'h40;
  localparam int unsigned EV_ALARM     = 0;
  localparam int unsigned EV_INDEX     = 1;
  localparam int unsigned EV_TRIM      = 2;
  localparam int unsigned N_EV         = 3;
  typedef struct packed {
    logic inc;
    logic dir;
  } srp_enc_s;
endpackage

// ===== tb/srp_enc_model.sv
`timescale 1ns/100ps
module srp_enc_model (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [7:0]  n,
  input  wire logic        dir,
  input  wire logic [1:0]  gap,
  output srp_pkg::srp_enc_s enc,
  output logic             busy
);
  logic [7:0] left_q;
  logic [1:0] wait_q;
  initial begin
    enc = '0;
    busy = 1'b0;
    left_q = 8'h00;
    wait_q = 2'h0;
  end
  // Direction toggles between pulses so a stale qualifier is never trusted
  always @(posedge core_clk) begin
    enc.inc <= 1'b0;
    enc.dir <= ~enc.dir;
    if (go) begin
      left_q <= n;
      wait_q <= gap;
      busy <= (n != 8'h00);
    end else if (left_q != 8'h00) begin
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else begin
        enc.inc <= 1'b1;
        enc.dir <= dir;
        left_q <= left_q - 8'h01;
        wait_q <= gap;
      end
    end else begin
      busy <= 1'b0;
    end
  end
endmodule // srp_enc_model

// ===== tb/srp_core_checker.sv
`timescale 1ns/100ps
module srp_core_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        idx_slave,
  input wire logic        alarm,
  input wire logic        index_ok,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire setup    = psel && !penable;
  wire rd_setup = setup && !pwrite;
  wire mode_off = psel && penable && pready && pwrite && paddr == srp_pkg::A_IMODE
                  && pwdata == 32'h0;
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  unmapped_err_a: assert property (setup && paddr == 8'h2C |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  trim_range_a: assert property (rd_setup && paddr == srp_pkg::A_TRIM |=>
    prdata >= srp_pkg::TRIM_MIN && prdata <= srp_pkg::TRIM_MAX) else $error("trim out of range");
  fact_range_a: assert property (rd_setup && (paddr == srp_pkg::A_FACT_M ||
    paddr == srp_pkg::A_FACT_S) |=> prdata >= srp_pkg::FACT_MIN && prdata <= srp_pkg::FACT_MAX)
    else $error("factor out of range");
  alert_range_a: assert property (rd_setup && paddr == srp_pkg::A_ALERT |=>
    prdata <= srp_pkg::WIN9999) else $error("alert out of range");
  index_edge_a: assert property ($rose(index_ok) |-> $past(idx_slave))
    else $error("index ok without slave marker");
  index_off_a: assert property (mode_off |-> ##[1:3] !index_ok)
    else $error("index ok kept outside index mode");
  reset_quiet_a: assert property ($rose(rst_n) |-> !pready && !alarm && !irq
    ##1 !pready && !irq) else $error("outputs active after reset");
  alarm_c: cover property ($rose(alarm));
  index_c: cover property ($rose(index_ok));
  irq_c: cover property ($rose(irq));
endmodule // srp_core_checker
bind srp_core srp_core_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .idx_slave(idx_slave), .alarm(alarm),
  .index_ok(index_ok), .irq(irq));

// ===== tb/srp_core_tb.sv
`timescale 1ns/100ps
module srp_core_tb;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } srp_row_s;
  localparam int CYC = 20;
  localparam srp_row_s ROWS [26] = '{
    {1'b0,8'h00,32'h0,32'h2710,1'b0}, {1'b0,8'h08,32'h0,32'h1,1'b0},
    {1'b0,8'h0C,32'h0,32'h0,1'b0}, {1'b0,8'h10,32'h0,32'h1,1'b0},
    {1'b0,8'h18,32'h0,32'h1E,1'b0}, {1'b0,8'h20,32'h0,32'h1,1'b0},
    {1'b0,8'h28,32'h0,32'h0,1'b0}, {1'b0,8'h2C,32'h0,32'h0,1'b1},
    {1'b0,8'h40,32'h0,32'h0,1'b0}, {1'b1,8'h00,32'h30000,32'h1869F,1'b0},
    {1'b1,8'h00,32'h2710,32'h2710,1'b0}, {1'b1,8'h04,32'h0,32'h1,1'b0},
    {1'b1,8'h04,32'h2710,32'h2710,1'b0}, {1'b1,8'h08,32'h3E8,32'h3E7,1'b0},
    {1'b1,8'h08,32'h1,32'h1,1'b0}, {1'b1,8'h0C,32'h3E8,32'h3E7,1'b0},
    {1'b1,8'h0C,32'h0,32'h0,1'b0}, {1'b1,8'h10,32'hF4240,32'hF423F,1'b0},
    {1'b1,8'h10,32'h0,32'h1,1'b0}, {1'b1,8'h18,32'h2710,32'h270F,1'b0},
    {1'b1,8'h1C,32'h10,32'hF,1'b0}, {1'b1,8'h20,32'h0,32'h1,1'b0},
    {1'b1,8'h24,32'h4,32'h3,1'b0}, {1'b1,8'h24,32'h0,32'h0,1'b0},
    {1'b1,8'h28,32'hA,32'h9,1'b0}, {1'b1,8'h28,32'h0,32'h0,1'b0}};
  localparam logic [3:0] MD [4] = '{4'h0, 4'h2, 4'h6, 4'h8};
  localparam logic [7:0] SN [4] = '{8'h04, 8'h02, 8'h02, 8'h02};
  logic              core_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic              trim_lead, trim_lag, idx_master, idx_slave, alarm, index_ok, irq;
  logic              go_m, go_s, dd, bm, bs;
  logic [7:0]        paddr, nn;
  logic [31:0]       pwdata, prdata, q, q0;
  srp_pkg::srp_enc_s m_enc, s_enc;
  int                err_count = 0;
  int                n_checks = 0;
  int                cyc_cnt = 0;
  srp_core #(.CYCLE_CLKS(CYC)) uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .m_enc(m_enc), .s_enc(s_enc), .trim_lead(trim_lead),
    .trim_lag(trim_lag), .idx_master(idx_master), .idx_slave(idx_slave), .alarm(alarm),
    .index_ok(index_ok), .corr_out(), .irq(irq));
  srp_enc_model u_menc (.core_clk(core_clk), .go(go_m), .n(nn), .dir(dd), .gap(2'h1),
    .enc(m_enc), .busy(bm));
  srp_enc_model u_senc (.core_clk(core_clk), .go(go_s), .n(nn), .dir(dd), .gap(2'h3),
    .enc(s_enc), .busy(bs));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, well above the expected run of about 3100 cycles
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic chb(input string nm, input logic x, input logic g);
    chk(nm, {31'h0, x}, {31'h0, g});
  endtask
  // No local limit: a missing ready is caught by the hang guard and fails the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cyc(input int n);
    repeat (n * CYC) @(posedge core_clk);
  endtask
  task automatic pulse(input logic s, input logic [7:0] n);
    int k;
    go_m <= !s;
    go_s <= s;
    nn <= n;
    @(posedge core_clk);
    go_m <= 1'b0;
    go_s <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((bm | bs) === 1'b1 && k < 500);
  endtask
  task automatic mark(input logic s);
    if (s) idx_slave <= 1'b1;
    else idx_master <= 1'b1;
    repeat (20) @(posedge core_clk);
    idx_slave <= 1'b0;
    idx_master <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
  initial begin
    {psel, penable, pwrite, trim_lead, trim_lag, idx_master, idx_slave} = '0;
    {go_m, go_s, dd, rst_n} = '0;
    paddr = 8'h00;
    nn = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    chk("reset outputs", 32'h0, {29'h0, pready, alarm, irq});
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    foreach (ROWS[i]) begin
      if (ROWS[i].w) apb(1'b1, ROWS[i].a, ROWS[i].d);
      apb(1'b0, ROWS[i].a, 32'h0);
      chk("register", ROWS[i].x, q);
      chb("slverr", ROWS[i].e, e);
    end
    apb(1'b1, srp_pkg::A_ALERT, 32'h2);
    apb(1'b1, srp_pkg::A_IEN, 32'h1);
    // Divider was left at its clamp by the register rows
    apb(1'b1, srp_pkg::A_CDIV, 32'h0);
    pulse(1'b0, 8'h05);
    cyc(2);
    chb("alarm master", 1'b1, alarm);
    chb("irq set", 1'b1, irq);
    apb(1'b1, srp_pkg::A_ICLR, 32'h7);
    repeat (3) @(posedge core_clk);
    chb("irq cleared", 1'b0, irq);
    apb(1'b1, srp_pkg::A_CDIV, 32'h2);
    cyc(2);
    chb("alarm divided", 1'b0, alarm);
    apb(1'b1, srp_pkg::A_CDIV, 32'h0);
    pulse(1'b1, 8'h05);
    cyc(2);
    chb("alarm balanced", 1'b0, alarm);
    apb(1'b1, srp_pkg::A_FACT_M, 32'h4E20);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, srp_pkg::A_MODE, {28'h0, MD[i]});
      pulse(1'b0, 8'h02);
      cyc(2);
      chb("alarm scaled", MD[i] == 4'h0, alarm);
      pulse(1'b1, SN[i]);
      cyc(2);
      chb("alarm rebalanced", 1'b0, alarm);
    end
    apb(1'b1, srp_pkg::A_MODE, 32'h0);
    apb(1'b1, srp_pkg::A_TRIM, 32'hA);
    trim_lead <= 1'b1;
    cyc(15);
    chb("trim slow", 1'b0, alarm);
    cyc(25);
    chb("trim lead", 1'b1, alarm);
    trim_lead <= 1'b0;
    trim_lag <= 1'b1;
    cyc(40);
    trim_lag <= 1'b0;
    cyc(2);
    chb("trim lag", 1'b0, alarm);
    apb(1'b0, srp_pkg::A_ISTAT, 32'h0);
    chb("trim event", 1'b1, q[2]);
    mark(1'b0);
    mark(1'b1);
    chb("index off", 1'b0, index_ok);
    apb(1'b1, srp_pkg::A_INTEG, 32'h0);
    apb(1'b1, srp_pkg::A_IMP, 32'h3E8);
    apb(1'b1, srp_pkg::A_IMODE, 32'h1);
    mark(1'b0);
    mark(1'b1);
    chb("index aligned", 1'b1, index_ok);
    apb(1'b1, srp_pkg::A_OFFS, 32'h32);
    mark(1'b0);
    mark(1'b1);
    chb("index offset", 1'b0, index_ok);
    mark(1'b0);
    pulse(1'b1, 8'h32);
    mark(1'b1);
    chb("index pulses", 1'b1, index_ok);
    apb(1'b0, srp_pkg::A_ISTAT, 32'h0);
    chb("index event", 1'b1, q[1]);
    apb(1'b1, srp_pkg::A_IMODE, 32'h0);
    repeat (4) @(posedge core_clk);
    chb("index cleared", 1'b0, index_ok);
    apb(1'b0, srp_pkg::A_ERR, 32'h0);
    q0 = q;
    apb(1'b1, srp_pkg::A_MODE, 32'h3);
    mark(1'b0);
    apb(1'b0, srp_pkg::A_ERR, 32'h0);
    chk("mode 3 step", q0 + 32'h32, q);
    apb(1'b1, srp_pkg::A_TRIM, 32'h1);
    apb(1'b1, srp_pkg::A_MODE, 32'h4);
    // Marker high for exactly one control cycle gives one factor step
    mark(1'b0);
    apb(1'b0, srp_pkg::A_FACT_M, 32'h0);
    chk("factor up", 32'h4E21, q);
    mark(1'b1);
    apb(1'b0, srp_pkg::A_FACT_M, 32'h0);
    chk("factor down", 32'h4E20, q);
    results();
  end
endmodule // srp_core_tb
